// >>> shared/lcea_pkg.sv
// Package: register map, field positions and timing constants of the line-cycle accumulator
package lcea_pkg;
    // Register byte addresses (word aligned, 32-bit data)
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_LINE_ENERGY = 8'h14;
    localparam logic [7:0] ADDR_LINE_ENERGY_HI = 8'h18;
    localparam logic [7:0] ADDR_HALF_CYCLES = 8'h1C;
    localparam logic [7:0] ADDR_PULSE_NUM = 8'h20;
    localparam logic [7:0] ADDR_PULSE_DEN = 8'h24;
    localparam logic [7:0] ADDR_POWER_GAIN = 8'h28;
    localparam logic [7:0] ADDR_TOTAL_ENERGY = 8'h2C;
    localparam logic [7:0] ADDR_TOTAL_ENERGY_HI = 8'h30;

    // Field positions
    localparam int MODE_LINE_CYCLE_BIT = 7;
    localparam int IRQ_CYCLE_DONE_BIT = 2;
    localparam int IRQ_WIDTH = 8;

    // Widths
    localparam int ENERGY_W = 40;
    localparam int HALF_CYCLE_W = 14;
    localparam int PULSE_ACC_W = 24;
    localparam int RATIO_W = 12;
    localparam int GAIN_W = 12;
    localparam int POWER_W = 24;

    // Reset values
    localparam logic [RATIO_W-1:0] PULSE_DEN_RESET = 12'h03F;
    localparam logic [RATIO_W-1:0] PULSE_NUM_RESET = 12'h000;
    localparam logic [HALF_CYCLE_W-1:0] HALF_CYCLE_RESET = 14'h0000;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h000;

    // Accumulation tick: one sample every four master clocks
    localparam int ACC_PERIOD_CLKS = 4;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/lcea_pulse_scaler.sv
// Pulse-rate scaler: passes (num+1) of every (den+1) input pulses
`timescale 1ns/1ps
module lcea_pulse_scaler #(
    parameter int RATIO_W = 12
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic pulse_in, // Unscaled pulse, one cycle
    input wire logic [RATIO_W-1:0] ratio_num, // Numerator field
    input wire logic [RATIO_W-1:0] ratio_den, // Denominator field
    output logic pulse_out // Scaled pulse, one cycle
);
    // Fractional accumulator: add num+1 per input, emit when reaching den+1.
    // Output never exceeds input rate while den >= num.
    logic [RATIO_W+1:0] frac;
    logic [RATIO_W+1:0] sum;
    logic [RATIO_W+1:0] limit;

    assign sum = frac + {2'h0, ratio_num} + 14'h0001;
    assign limit = {2'h0, ratio_den} + 14'h0001;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            frac <= '0;
            pulse_out <= 1'b0;
        end
        else
        begin
            pulse_out <= 1'b0;
            if (pulse_in)
            begin
                if (sum >= limit)
                begin
                    frac <= sum - limit;
                    pulse_out <= 1'b1;
                end
                else
                begin
                    frac <= sum;
                end
            end
        end
    end
endmodule

// >>> hdl/lcea_top.sv
// Line-cycle energy accumulator with pulse output and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module lcea_top (
    input wire logic core_clk, // 200 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [23:0] power_lowpass, // Filtered active power, signed
    input wire logic zero_cross_in, // Voltage zero-crossing level, async
    output logic energy_pulse_out, // Scaled energy pulse, one cycle
    output logic interrupt_request_n, // Interrupt, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    localparam int EW = lcea_pkg::ENERGY_W;
    localparam int PW = lcea_pkg::POWER_W;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mode;
    logic [lcea_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [lcea_pkg::IRQ_WIDTH-1:0] irq_enable;
    logic [lcea_pkg::HALF_CYCLE_W-1:0] half_cycle_count;
    logic [lcea_pkg::RATIO_W-1:0] pulse_ratio_numerator;
    logic [lcea_pkg::RATIO_W-1:0] pulse_ratio_denominator;
    logic [lcea_pkg::GAIN_W-1:0] power_gain;
    logic [EW-1:0] line_cycle_energy;
    logic [EW-1:0] total_energy;

    logic mode_on;
    assign mode_on = mode[lcea_pkg::MODE_LINE_CYCLE_BIT];

    // ------------------------------------------------------------
    // Sample tick and zero-crossing input
    // ------------------------------------------------------------
    logic [1:0] tick_cnt;
    logic tick;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 2'h1;
    end
    assign tick = (tick_cnt == 2'(lcea_pkg::ACC_PERIOD_CLKS - 1));

    logic zx_meta;
    logic zx_sync;
    logic zx_prev;
    logic zx_edge;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            zx_meta <= 1'b0;
            zx_sync <= 1'b0;
            zx_prev <= 1'b0;
        end
        else
        begin
            zx_meta <= zero_cross_in;
            zx_sync <= zx_meta;
            zx_prev <= zx_sync;
        end
    end
    // Either edge of the level marks one zero crossing, i.e. one half cycle
    assign zx_edge = zx_sync ^ zx_prev;

    // ------------------------------------------------------------
    // Gained power
    // ------------------------------------------------------------
    // Gain is signed: power * (1 + gain/4096); one step is 1/4096 = 0.0244%
    logic signed [PW+lcea_pkg::GAIN_W:0] gain_prod;
    logic signed [PW-1:0] power_gained;
    assign gain_prod = $signed(power_lowpass) * $signed({power_gain[lcea_pkg::GAIN_W-1], power_gain});
    assign power_gained = $signed(power_lowpass) + $signed(gain_prod[PW+lcea_pkg::GAIN_W-1:lcea_pkg::GAIN_W]);

    logic [EW-1:0] power_ext;
    assign power_ext = {{(EW-PW){power_gained[PW-1]}}, power_gained};

    // ------------------------------------------------------------
    // Line-cycle accumulation
    // ------------------------------------------------------------
    typedef enum logic [1:0] {LC_IDLE = 2'b00, LC_WAIT = 2'b01, LC_RUN = 2'b11} lcea_state_e;
    lcea_state_e lc_state;
    logic [EW-1:0] line_acc;
    logic [lcea_pkg::HALF_CYCLE_W-1:0] half_seen;
    logic cycle_done;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            lc_state <= LC_IDLE;
            line_acc <= '0;
            half_seen <= '0;
            line_cycle_energy <= '0;
            cycle_done <= 1'b0;
        end
        else
        begin
            cycle_done <= 1'b0;
            if (!mode_on)
            begin
                lc_state <= LC_IDLE;
            end
            else
            begin
                unique case (lc_state)
                    LC_IDLE:
                        lc_state <= LC_WAIT;
                    LC_WAIT:
                        if (zx_edge)
                        begin
                            lc_state <= LC_RUN;
                            line_acc <= '0;
                            half_seen <= '0;
                        end
                    LC_RUN:
                    begin
                        if (zx_edge)
                        begin
                            // A zero count is treated as one half cycle
                            if (half_seen + 14'h0001 >= half_cycle_count)
                            begin
                                line_cycle_energy <= line_acc + (tick ? power_ext : '0);
                                cycle_done <= 1'b1;
                                line_acc <= '0;
                                half_seen <= '0;
                            end
                            else
                            begin
                                half_seen <= half_seen + 14'h0001;
                                if (tick)
                                    line_acc <= line_acc + power_ext;
                            end
                        end
                        else if (tick)
                        begin
                            line_acc <= line_acc + power_ext;
                        end
                    end
                    default:
                        lc_state <= LC_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Total energy and unscaled pulse train
    // ------------------------------------------------------------
    logic [lcea_pkg::PULSE_ACC_W-1:0] pulse_acc;
    logic [lcea_pkg::PULSE_ACC_W-1:0] next_pulse_acc;
    logic raw_pulse;
    assign next_pulse_acc = pulse_acc + power_gained;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            total_energy <= '0;
            pulse_acc <= '0;
            raw_pulse <= 1'b0;
        end
        else
        begin
            raw_pulse <= 1'b0;
            if (tick)
            begin
                total_energy <= total_energy + power_ext;
                pulse_acc <= next_pulse_acc;
                raw_pulse <= !pulse_acc[lcea_pkg::PULSE_ACC_W-1]
                    && next_pulse_acc[lcea_pkg::PULSE_ACC_W-1];
            end
        end
    end

    lcea_pulse_scaler #(
        .RATIO_W(lcea_pkg::RATIO_W)
    ) u_scaler (
        .core_clk(core_clk),
        .rst(rst),
        .pulse_in(raw_pulse),
        .ratio_num(pulse_ratio_numerator),
        .ratio_den(pulse_ratio_denominator),
        .pulse_out(energy_pulse_out)
    );

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic clear_hit;
    logic [lcea_pkg::IRQ_WIDTH-1:0] clear_bits;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign clear_hit = do_write && (aw_addr == lcea_pkg::ADDR_IRQ_CLEAR) && w_strb[0];
    assign clear_bits = clear_hit ? w_data[lcea_pkg::IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= lcea_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (aw_addr)
                    lcea_pkg::ADDR_MODE, lcea_pkg::ADDR_IRQ_ENABLE, lcea_pkg::ADDR_IRQ_CLEAR,
                    lcea_pkg::ADDR_HALF_CYCLES, lcea_pkg::ADDR_PULSE_NUM,
                    lcea_pkg::ADDR_PULSE_DEN, lcea_pkg::ADDR_POWER_GAIN:
                        s_axi_bresp <= lcea_pkg::RESP_OKAY;
                    default:
                        s_axi_bresp <= lcea_pkg::RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software-writable registers; byte lanes honoured per field
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mode <= '0;
            irq_enable <= '0;
            half_cycle_count <= lcea_pkg::HALF_CYCLE_RESET;
            pulse_ratio_numerator <= lcea_pkg::PULSE_NUM_RESET;
            pulse_ratio_denominator <= lcea_pkg::PULSE_DEN_RESET;
            power_gain <= lcea_pkg::GAIN_RESET;
        end
        else if (do_write)
        begin
            if (aw_addr == lcea_pkg::ADDR_MODE && w_strb[0])
                mode <= w_data[7:0];
            if (aw_addr == lcea_pkg::ADDR_IRQ_ENABLE && w_strb[0])
                irq_enable <= w_data[lcea_pkg::IRQ_WIDTH-1:0];
            if (aw_addr == lcea_pkg::ADDR_HALF_CYCLES && (&w_strb[1:0]))
                half_cycle_count <= w_data[lcea_pkg::HALF_CYCLE_W-1:0];
            if (aw_addr == lcea_pkg::ADDR_PULSE_NUM && (&w_strb[1:0]))
                pulse_ratio_numerator <= w_data[lcea_pkg::RATIO_W-1:0];
            if (aw_addr == lcea_pkg::ADDR_PULSE_DEN && (&w_strb[1:0]))
                pulse_ratio_denominator <= w_data[lcea_pkg::RATIO_W-1:0];
            if (aw_addr == lcea_pkg::ADDR_POWER_GAIN && (&w_strb[1:0]))
                power_gain <= w_data[lcea_pkg::GAIN_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Set wins over a clear landing in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irq_status <= '0;
            interrupt_request_n <= 1'b1;
        end
        else
        begin
            irq_status <= (irq_status & ~clear_bits)
                | ({{(lcea_pkg::IRQ_WIDTH-1){1'b0}}, cycle_done} << lcea_pkg::IRQ_CYCLE_DONE_BIT);
            interrupt_request_n <= !(|(irq_status & irq_enable));
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= lcea_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= lcea_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    lcea_pkg::ADDR_MODE: s_axi_rdata <= {24'h000000, mode};
                    lcea_pkg::ADDR_IRQ_STATUS: s_axi_rdata <= {24'h000000, irq_status};
                    lcea_pkg::ADDR_IRQ_ENABLE: s_axi_rdata <= {24'h000000, irq_enable};
                    lcea_pkg::ADDR_IRQ_CLEAR: s_axi_rdata <= 32'h00000000;
                    lcea_pkg::ADDR_LINE_ENERGY: s_axi_rdata <= line_cycle_energy[31:0];
                    lcea_pkg::ADDR_LINE_ENERGY_HI:
                        s_axi_rdata <= {{24{line_cycle_energy[EW-1]}}, line_cycle_energy[EW-1:32]};
                    lcea_pkg::ADDR_HALF_CYCLES: s_axi_rdata <= {18'h00000, half_cycle_count};
                    lcea_pkg::ADDR_PULSE_NUM: s_axi_rdata <= {20'h00000, pulse_ratio_numerator};
                    lcea_pkg::ADDR_PULSE_DEN: s_axi_rdata <= {20'h00000, pulse_ratio_denominator};
                    lcea_pkg::ADDR_POWER_GAIN: s_axi_rdata <= {20'h00000, power_gain};
                    lcea_pkg::ADDR_TOTAL_ENERGY: s_axi_rdata <= total_energy[31:0];
                    lcea_pkg::ADDR_TOTAL_ENERGY_HI:
                        s_axi_rdata <= {{24{total_energy[EW-1]}}, total_energy[EW-1:32]};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= lcea_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_mode_leave_idle: assert property (@(posedge core_clk) disable iff (rst)
        !mode_on |=> lc_state == LC_IDLE) else $error("mode off but not idle");
    chk_done_needs_zx: assert property (@(posedge core_clk) disable iff (rst)
        $rose(cycle_done) |-> $past(zx_edge)) else $error("period ended off crossing");
    chk_done_sets_flag: assert property (@(posedge core_clk) disable iff (rst)
        cycle_done |=> irq_status[lcea_pkg::IRQ_CYCLE_DONE_BIT]) else $error("flag not set");
    chk_irq_follows: assert property (@(posedge core_clk) disable iff (rst)
        (irq_status[lcea_pkg::IRQ_CYCLE_DONE_BIT] && irq_enable[lcea_pkg::IRQ_CYCLE_DONE_BIT])
        |=> !interrupt_request_n) else $error("irq not asserted");
    chk_restart_run: assert property (@(posedge core_clk) disable iff (rst)
        (cycle_done && mode_on) |-> lc_state == LC_RUN && half_seen == '0)
        else $error("no restart after period");
    chk_tick_period: assert property (@(posedge core_clk) disable iff (rst)
        tick |=> !tick [*3] ##1 tick) else $error("tick not every four clocks");
    chk_pulse_msb: assert property (@(posedge core_clk) disable iff (rst)
        raw_pulse |-> pulse_acc[lcea_pkg::PULSE_ACC_W-1] && !$past(pulse_acc[lcea_pkg::PULSE_ACC_W-1]))
        else $error("pulse without msb rise");
    chk_energy_load: assert property (@(posedge core_clk) disable iff (rst)
        !cycle_done && !$past(cycle_done) |-> $stable(line_cycle_energy))
        else $error("energy changed outside period end");
    // Only judged while the count register is left alone; a host may lower it mid-period
    chk_half_bound: assert property (@(posedge core_clk) disable iff (rst)
        lc_state == LC_RUN && $changed(half_seen) && half_seen != '0
        && $stable(half_cycle_count) |-> half_seen < half_cycle_count)
        else $error("half cycle counter overrun");
endmodule

// >>> sim/lcea_line_model.sv
// Line-side model: voltage zero crossings and pulse counting
`timescale 1ns/1ps
module lcea_line_model (
    input wire logic core_clk, // System clock
    input wire logic run, // Crossings enabled
    input wire logic pulse, // Energy pulse
    input wire logic clr, // Clear pulse count
    output logic zx, // Voltage polarity
    output int count // Pulses seen
);
    int t = 0;
    initial zx = 1'b0;
    initial count = 0;
    // 40 clocks per half cycle, a whole number of sample ticks
    always @(posedge core_clk)
    begin
        t <= (run && t != 39) ? t + 1 : 0;
        if (run && t == 39)
            zx <= ~zx;
    end
    always @(posedge core_clk)
        count <= clr ? 0 : count + int'(pulse);
endmodule

// >>> sim/lcea_top_tb.sv
// Testbench: registers, line-cycle accumulation, interrupt and pulse rate
`timescale 1ns/1ps
module lcea_top_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [23:0] power = 24'h000000;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic run = 1'b0, clr = 1'b0;
    logic zx, pulse, irq_n, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs, bs;
    logic [31:0] rdata, rd;
    int cnt;
    int bad_count = 0;
    int n_tests = 0;
    always #2.5 core_clk = ~core_clk;
    lcea_top DUT (.core_clk(core_clk), .rst(rst), .power_lowpass(power), .zero_cross_in(zx),
        .energy_pulse_out(pulse), .interrupt_request_n(irq_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    lcea_line_model line (.core_clk(core_clk), .run(run), .pulse(pulse), .clr(clr), .zx(zx),
        .count(cnt));
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid || awvalid || wvalid);
        bs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdreg(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid || arvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_irq;
        int i = 0;
        while (irq_n !== 1'b0 && i < 400)
        begin
            @(posedge core_clk);
            i++;
        end
        check(i < 400, 1);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rdreg(lcea_pkg::ADDR_PULSE_DEN);
        check(rd, 32'h0000003F);
        rdreg(lcea_pkg::ADDR_PULSE_NUM);
        check(rd, 0);
        rdreg(8'h40);
        check(rs, lcea_pkg::RESP_SLVERR);
        check(rd, 32'h00000000);
        wr(8'h40, 32'h00000001);
        check(bs, lcea_pkg::RESP_SLVERR);
        wr(lcea_pkg::ADDR_HALF_CYCLES, 32'hFFFFFFFF);
        check(bs, lcea_pkg::RESP_OKAY);
        rdreg(lcea_pkg::ADDR_HALF_CYCLES);
        check(rd, 32'h00003FFF);
        check(rs, lcea_pkg::RESP_OKAY);
        check(irq_n, 1);
        $display("reset test done");
    endtask
    task automatic t_line(input logic [23:0] p, input logic [11:0] g, input logic [39:0] e);
        logic [31:0] lo;
        power <= p;
        wr(lcea_pkg::ADDR_POWER_GAIN, {20'h00000, g});
        wr(lcea_pkg::ADDR_HALF_CYCLES, 2);
        wr(lcea_pkg::ADDR_IRQ_ENABLE, 4);
        wr(lcea_pkg::ADDR_MODE, 32'h00000080);
        run <= 1'b1;
        wait_irq;
        rdreg(lcea_pkg::ADDR_IRQ_STATUS);
        check(rd[2], 1);
        wr(lcea_pkg::ADDR_IRQ_ENABLE, 0);
        repeat (2) @(posedge core_clk);
        check(irq_n, 1);
        // First result after enabling is thrown away
        wr(lcea_pkg::ADDR_IRQ_CLEAR, 4);
        wr(lcea_pkg::ADDR_IRQ_ENABLE, 4);
        wait_irq;
        rdreg(lcea_pkg::ADDR_LINE_ENERGY);
        lo = rd;
        rdreg(lcea_pkg::ADDR_LINE_ENERGY_HI);
        check({rd, lo}, {{24{e[39]}}, e});
        wr(lcea_pkg::ADDR_MODE, 0);
        wr(lcea_pkg::ADDR_IRQ_CLEAR, 4);
        repeat (200) @(posedge core_clk);
        check(irq_n, 1);
        run <= 1'b0;
        $display("line-cycle test done");
    endtask
    task automatic t_pulse(input logic [11:0] den, input int lo_n, input int hi_n);
        power <= 24'h100000;
        wr(lcea_pkg::ADDR_POWER_GAIN, 0);
        wr(lcea_pkg::ADDR_PULSE_DEN, {20'h00000, den});
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (1024) @(posedge core_clk);
        check(cnt >= lo_n && cnt <= hi_n, 1);
        $display("pulse test done");
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_line(24'h000100, 12'h000, 40'h0000001400);
        t_line(24'hFFFF00, 12'h000, 40'hFFFFFFEC00);
        t_line(24'h000100, 12'h400, 40'h0000001900);
        t_pulse(12'h000, 15, 17);
        t_pulse(12'h003, 3, 5);
        finish_test;
    end
    initial
    begin
        #(40000 * 5);
        bad_count++;
        finish_test;
    end
endmodule
